// file: cpu_addr_mode_map.svh
// Purpose: named constants of the operand address decoder
// Assumes: included by its bare name wherever the constants are used
// Notes: opcode rows are the high nibble of the opcode byte
//
// Contract
// RULE1: short forms keep the operand address inside page zero, 0000h to 00FFh. Short indexed and short indirect indexed here reach 01FEh.
// RULE2: long forms reach the full 64 Kbyte space and use more bytes.
// RULE3: read-modify-write opcode rows decode to short addressing forms only.
// RULE4: inherent instructions are one opcode byte with no operand bytes fetched.
// RULE5: immediate instructions carry one operand byte used as a value.
// RULE6: short direct fetches one address byte, used as a page-zero address.
// RULE7: long direct fetches two bytes forming a 16-bit operand address.
// RULE8: indexed address is the unsigned sum of X or Y and the offset.
// RULE9: no-offset indexed fetches nothing and uses the index value alone.
// RULE10: short indexed fetches one offset byte; the sum may reach 1FE.
// RULE11: long indexed fetches a 16-bit offset and adds the index register.
// RULE12: indirect fetches a pointer address byte, reads byte or word pointer.
// RULE13: indirect indexed reads a pointer from page zero and adds the index.
// RULE14: relative mode adds a signed 8-bit offset to the program counter.
// RULE15: relative direct takes the offset from the byte after the opcode.
// RULE16: relative indirect reads the offset from the page-zero address given.
// RULE17: prefix 90 makes an X based instruction use index register Y.
// RULE18: prefix 92 selects indirect forms; prefix 91 selects Y indirect indexed.
// RULE19: set mask gives interrupt level 3, clear mask gives level 0.
// RULE20: halt enters lowest power mode, wait for interrupt enters wait mode.
// RULE21: operand bytes fetch in ascending order, high byte first for words.
`ifndef CPU_ADDR_MODE_MAP_SVH
`define CPU_ADDR_MODE_MAP_SVH

// ==========================================================
// prefix and special opcodes
`define PRE_Y_CODE 8'h90
`define PRE_IND_CODE 8'h92
`define PRE_YIND_CODE 8'h91
`define OP_SET_MASK 8'h9B
`define OP_CLR_MASK 8'h9A
`define OP_HALT 8'h8E
`define OP_WAIT 8'h8F
`define OP_REL_CALL 8'hAD

// ==========================================================
// opcode rows
`define ROW_BITREL 4'h0
`define ROW_BIT 4'h1
`define ROW_REL 4'h2
`define ROW_RMW_DIR 4'h3
`define ROW_INH_A 4'h4
`define ROW_INH_X 4'h5
`define ROW_RMW_IDX_S 4'h6
`define ROW_RMW_IDX0 4'h7
`define ROW_INH_8 4'h8
`define ROW_INH_9 4'h9
`define ROW_IMM 4'hA
`define ROW_DIR_S 4'hB
`define ROW_DIR_L 4'hC
`define ROW_IDX_L 4'hD
`define ROW_IDX_S 4'hE
`define ROW_IDX0 4'hF

// ==========================================================
// byte counts and reset values
`define NO_BYTE 2'h0
`define ONE_BYTE 2'h1
`define TWO_BYTE 2'h2
`define LEN_ZERO 3'h0
`define LEN_ONE 3'h1
`define LEN_TWO 3'h2
`define LEN_THREE 3'h3
`define MASK_SET 2'h3
`define MASK_CLR 2'h0
`define MASK_RESET 2'h3
`define PC_RESET 16'h0000
`define ZERO_PAGE 8'h00

`endif

// file: cpu_addr_mode_pkg.sv
// Purpose: types of the operand address decoder
// Assumes: nothing
// Notes: none
package cpu_addr_mode_pkg;
   typedef enum logic [4:0] {
      M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX0, M_IDX_S, M_IDX_L,
      M_IND_S, M_IND_L, M_IIDX_S, M_IIDX_L, M_REL_D, M_REL_I,
      M_BIT_D, M_BIT_I, M_BITREL_D, M_BITREL_I
   } mode_type;
   typedef enum logic [1:0] {P_NONE, P_Y, P_IND, P_YIND} pre_type;
   typedef enum logic [2:0] {
      ST_IDLE, ST_OPC, ST_OPR, ST_PTR, ST_CALC, ST_HALT, ST_WAIT
   } state_type;
   typedef struct packed {
      mode_type mode;
      logic [1:0] nbytes;
      logic [1:0] pbytes;
      logic idx;
      logic use_y;
      logic rmw;
   } dec_type;
endpackage

// file: cpu_addr_mode_decoder.sv
// Purpose: decode addressing mode, fetch operand bytes, form the address
// Assumes: memories answer on the same clock; ack may come any cycle later
// Notes: a request stays up until acked or dropped by a pc load; address moves only after an ack or a load
`timescale 1ns/10ps
`include "cpu_addr_mode_map.svh"
module cpu_addr_mode_decoder
   import cpu_addr_mode_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // program counter load and wake-up
   input wire logic pc_load_i,
   input wire logic [15:0] pc_value_i,
   input wire logic wake_i,
   // index registers
   input wire logic [7:0] x_i,
   input wire logic [7:0] y_i,
   // program byte fetch
   output logic prog_rd_o,
   output logic [15:0] prog_addr_o,
   input wire logic [7:0] prog_data_i,
   input wire logic prog_ack_i,
   // pointer read from data memory
   output logic data_rd_o,
   output logic [15:0] data_addr_o,
   input wire logic [7:0] data_data_i,
   input wire logic data_ack_i,
   // result of one instruction
   output logic ea_valid_o,
   output logic [15:0] ea_o,
   output logic [15:0] branch_o,
   output logic [7:0] imm_o,
   output mode_type mode_o,
   output logic [2:0] len_o,
   // processor status
   output logic [1:0] irq_level_o,
   output logic halt_o,
   output logic wait_o
);

   // ==========================================================
   // helpers
   function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                              input logic [7:0] ofs);
      rel_target = pc + {{8{ofs[7]}}, ofs};
   endfunction

   function automatic dec_type decode_op(input pre_type pre,
                                         input logic [7:0] op);
      dec_type d;
      logic ind;
      d = '0;
      ind = (pre == P_IND) || (pre == P_YIND);
      d.use_y = (pre == P_Y) || (pre == P_YIND); // [RULE17] [RULE18]
      unique case (op[7:4])
         `ROW_BITREL: begin
            d.mode = ind ? M_BITREL_I : M_BITREL_D; // [RULE18]
            d.nbytes = `TWO_BYTE;
            d.pbytes = ind ? `ONE_BYTE : `NO_BYTE;
            d.rmw = 1'b1;
         end
         `ROW_BIT: begin
            d.mode = ind ? M_BIT_I : M_BIT_D;
            d.nbytes = `ONE_BYTE;
            d.pbytes = ind ? `ONE_BYTE : `NO_BYTE;
            d.rmw = 1'b1;
         end
         `ROW_REL: begin
            d.mode = ind ? M_REL_I : M_REL_D; // [RULE15] [RULE16]
            d.nbytes = `ONE_BYTE;
            d.pbytes = ind ? `ONE_BYTE : `NO_BYTE;
         end
         `ROW_RMW_DIR: begin
            d.mode = ind ? M_IND_S : M_DIR_S; // [RULE3]
            d.nbytes = `ONE_BYTE;
            d.pbytes = ind ? `ONE_BYTE : `NO_BYTE;
            d.rmw = 1'b1;
         end
         `ROW_RMW_IDX_S: begin
            d.mode = ind ? M_IIDX_S : M_IDX_S; // [RULE3]
            d.nbytes = `ONE_BYTE;
            d.pbytes = ind ? `ONE_BYTE : `NO_BYTE;
            d.idx = 1'b1;
            d.rmw = 1'b1;
         end
         `ROW_RMW_IDX0: begin
            d.mode = M_IDX0; // [RULE3] [RULE9]
            d.idx = 1'b1;
            d.rmw = 1'b1;
         end
         `ROW_INH_A, `ROW_INH_X, `ROW_INH_8, `ROW_INH_9: begin
            d.mode = M_INH; // [RULE4]
         end
         `ROW_IMM: begin
            d.mode = (op == `OP_REL_CALL) ? M_REL_D : M_IMM; // [RULE5]
            d.nbytes = `ONE_BYTE;
         end
         `ROW_DIR_S: begin
            d.mode = ind ? M_IND_S : M_DIR_S; // [RULE6] [RULE12]
            d.nbytes = `ONE_BYTE;
            d.pbytes = ind ? `ONE_BYTE : `NO_BYTE;
         end
         `ROW_DIR_L: begin
            d.mode = ind ? M_IND_L : M_DIR_L; // [RULE7] [RULE12]
            d.nbytes = ind ? `ONE_BYTE : `TWO_BYTE;
            d.pbytes = ind ? `TWO_BYTE : `NO_BYTE;
         end
         `ROW_IDX_L: begin
            d.mode = ind ? M_IIDX_L : M_IDX_L; // [RULE11] [RULE13]
            d.nbytes = ind ? `ONE_BYTE : `TWO_BYTE;
            d.pbytes = ind ? `TWO_BYTE : `NO_BYTE;
            d.idx = 1'b1;
         end
         `ROW_IDX_S: begin
            d.mode = ind ? M_IIDX_S : M_IDX_S; // [RULE10] [RULE13]
            d.nbytes = `ONE_BYTE;
            d.pbytes = ind ? `ONE_BYTE : `NO_BYTE;
            d.idx = 1'b1;
         end
         `ROW_IDX0: begin
            d.mode = M_IDX0; // [RULE9]
            d.idx = 1'b1;
         end
      endcase
      decode_op = d;
   endfunction

   // ==========================================================
   // sequencing state
   state_type state_reg, state_next;
   logic [15:0] pc_reg, pc_next;
   logic [7:0] opc_reg, opc_next;
   pre_type pre_reg, pre_next;
   dec_type dec_reg, dec_next;
   logic [15:0] opr_reg, opr_next;
   logic [15:0] ptr_reg, ptr_next;
   logic [1:0] cnt_reg, cnt_next;
   logic [1:0] pcnt_reg, pcnt_next;
   logic [2:0] len_reg, len_next;
   logic [15:0] daddr_reg, daddr_next;
   logic prd_reg, prd_next;
   logic drd_reg, drd_next;
   logic acc_p, acc_d;
   dec_type d_new;
   logic [7:0] pa;

   assign acc_p = prd_reg && prog_ack_i;
   assign acc_d = drd_reg && data_ack_i;

   // next values of the fetch and pointer sequencer
   always_comb begin
      state_next = state_reg;
      pc_next = pc_reg;
      opc_next = opc_reg;
      pre_next = pre_reg;
      dec_next = dec_reg;
      opr_next = opr_reg;
      ptr_next = ptr_reg;
      cnt_next = cnt_reg;
      pcnt_next = pcnt_reg;
      len_next = len_reg;
      daddr_next = daddr_reg;
      d_new = decode_op(pre_reg, prog_data_i);
      pa = `ZERO_PAGE;
      unique case (state_reg)
         ST_IDLE: begin
         end
         ST_OPC: if (acc_p) begin
            pc_next = pc_reg + 16'h0001; // [RULE21]
            len_next = len_reg + `LEN_ONE;
            if (pre_reg == P_NONE && prog_data_i == `PRE_Y_CODE) begin
               pre_next = P_Y; // [RULE17]
            end else if (pre_reg == P_NONE &&
                         prog_data_i == `PRE_IND_CODE) begin
               pre_next = P_IND; // [RULE18]
            end else if (pre_reg == P_NONE &&
                         prog_data_i == `PRE_YIND_CODE) begin
               pre_next = P_YIND; // [RULE18]
            end else begin
               opc_next = prog_data_i;
               dec_next = d_new;
               opr_next = 16'h0000;
               ptr_next = 16'h0000;
               cnt_next = d_new.nbytes;
               state_next = (d_new.nbytes != `NO_BYTE) ? ST_OPR :
                            ST_CALC; // [RULE4]
            end
         end
         ST_OPR: if (acc_p) begin
            pc_next = pc_reg + 16'h0001;
            len_next = len_reg + `LEN_ONE;
            opr_next = {opr_reg[7:0], prog_data_i}; // [RULE21]
            cnt_next = cnt_reg - `ONE_BYTE;
            if (cnt_reg == `ONE_BYTE) begin
               pcnt_next = dec_reg.pbytes;
               pa = (dec_reg.mode == M_BITREL_I) ? opr_reg[7:0] :
                    prog_data_i;
               daddr_next = {`ZERO_PAGE, pa}; // [RULE12] [RULE13]
               state_next = (dec_reg.pbytes != `NO_BYTE) ? ST_PTR :
                            ST_CALC;
            end
         end
         ST_PTR: if (acc_d) begin
            ptr_next = {ptr_reg[7:0], data_data_i}; // [RULE12]
            pcnt_next = pcnt_reg - `ONE_BYTE;
            daddr_next = {`ZERO_PAGE, daddr_reg[7:0] + 8'h01};
            if (pcnt_reg == `ONE_BYTE) begin
               state_next = ST_CALC;
            end
         end
         ST_CALC: begin
            pre_next = P_NONE;
            len_next = `LEN_ZERO;
            if (opc_reg == `OP_HALT && dec_reg.mode == M_INH) begin
               state_next = ST_HALT; // [RULE20]
            end else if (opc_reg == `OP_WAIT &&
                         dec_reg.mode == M_INH) begin
               state_next = ST_WAIT; // [RULE20]
            end else begin
               state_next = ST_OPC;
            end
         end
         ST_HALT, ST_WAIT: if (wake_i) begin
            state_next = ST_OPC;
         end
      endcase
      if (pc_load_i) begin
         state_next = ST_OPC;
         pc_next = pc_value_i;
         pre_next = P_NONE;
         len_next = `LEN_ZERO;
      end
      // a load drops the request for one cycle, so that an answer still
      // in flight for the old address is refused, not taken as an opcode
      prd_next = ((state_next == ST_OPC) || (state_next == ST_OPR)) &&
                 !pc_load_i; // [RULE21]
      drd_next = (state_next == ST_PTR);
   end

   // registers of the sequencer
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= ST_IDLE;
         pc_reg <= `PC_RESET;
         opc_reg <= 8'h00;
         pre_reg <= P_NONE;
         dec_reg <= '0;
         opr_reg <= 16'h0000;
         ptr_reg <= 16'h0000;
         cnt_reg <= `NO_BYTE;
         pcnt_reg <= `NO_BYTE;
         len_reg <= `LEN_ZERO;
         daddr_reg <= 16'h0000;
         prd_reg <= 1'b0;
         drd_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         pc_reg <= pc_next;
         opc_reg <= opc_next;
         pre_reg <= pre_next;
         dec_reg <= dec_next;
         opr_reg <= opr_next;
         ptr_reg <= ptr_next;
         cnt_reg <= cnt_next;
         pcnt_reg <= pcnt_next;
         len_reg <= len_next;
         daddr_reg <= daddr_next;
         prd_reg <= prd_next;
         drd_reg <= drd_next;
      end
   end

   // ==========================================================
   // result state
   logic [15:0] ea_reg, ea_next;
   logic [15:0] br_reg, br_next;
   logic [7:0] imm_reg, imm_next;
   logic [7:0] idx_reg, idx_next;
   mode_type mode_reg, mode_next;
   logic [2:0] lenq_reg, lenq_next;
   logic val_reg, val_next;
   logic [1:0] mask_reg, mask_next;
   logic halt_reg, halt_next;
   logic wait_reg, wait_next;
   logic [15:0] idxw;

   // effective address and status updates at the end of an instruction
   always_comb begin
      ea_next = ea_reg;
      br_next = br_reg;
      imm_next = imm_reg;
      idx_next = idx_reg;
      mode_next = mode_reg;
      lenq_next = lenq_reg;
      mask_next = mask_reg;
      halt_next = halt_reg && !wake_i;
      wait_next = wait_reg && !wake_i;
      val_next = 1'b0;
      idx_next = dec_reg.use_y ? y_i : x_i; // [RULE17]
      idxw = {`ZERO_PAGE, idx_next};
      if (state_reg == ST_CALC) begin
         val_next = 1'b1;
         mode_next = dec_reg.mode;
         lenq_next = len_reg;
         imm_next = opr_reg[7:0]; // [RULE5]
         br_next = 16'h0000;
         unique case (dec_reg.mode)
            M_INH, M_IMM: ea_next = 16'h0000;
            M_DIR_S, M_DIR_L, M_BIT_D: ea_next = opr_reg; // [RULE1] [RULE2]
            M_IDX0, M_IDX_S, M_IDX_L: ea_next = opr_reg + idxw; // [RULE8]
            M_IND_S, M_IND_L, M_BIT_I: ea_next = ptr_reg; // [RULE12]
            M_IIDX_S, M_IIDX_L: ea_next = ptr_reg + idxw; // [RULE13]
            M_REL_D: begin
               ea_next = rel_target(pc_reg, opr_reg[7:0]); // [RULE14]
               br_next = ea_next;
            end
            M_REL_I: begin
               ea_next = rel_target(pc_reg, ptr_reg[7:0]); // [RULE16]
               br_next = ea_next;
            end
            M_BITREL_D: begin
               ea_next = {`ZERO_PAGE, opr_reg[15:8]};
               br_next = rel_target(pc_reg, opr_reg[7:0]);
            end
            M_BITREL_I: begin
               ea_next = {`ZERO_PAGE, ptr_reg[7:0]};
               br_next = rel_target(pc_reg, opr_reg[7:0]);
            end
         endcase
         if (dec_reg.mode == M_INH) begin
            if (opc_reg == `OP_SET_MASK) mask_next = `MASK_SET; // [RULE19]
            if (opc_reg == `OP_CLR_MASK) mask_next = `MASK_CLR; // [RULE19]
            if (opc_reg == `OP_HALT) halt_next = 1'b1; // [RULE20]
            if (opc_reg == `OP_WAIT) wait_next = 1'b1; // [RULE20]
         end
      end
   end

   // registers of the result
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ea_reg <= 16'h0000;
         br_reg <= 16'h0000;
         imm_reg <= 8'h00;
         idx_reg <= 8'h00;
         mode_reg <= M_INH;
         lenq_reg <= `LEN_ZERO;
         val_reg <= 1'b0;
         mask_reg <= `MASK_RESET;
         halt_reg <= 1'b0;
         wait_reg <= 1'b0;
      end else begin
         ea_reg <= ea_next;
         br_reg <= br_next;
         imm_reg <= imm_next;
         idx_reg <= idx_next;
         mode_reg <= mode_next;
         lenq_reg <= lenq_next;
         val_reg <= val_next;
         mask_reg <= mask_next;
         halt_reg <= halt_next;
         wait_reg <= wait_next;
      end
   end

   // outputs straight from flip-flops
   assign prog_rd_o = prd_reg;
   assign prog_addr_o = pc_reg;
   assign data_rd_o = drd_reg;
   assign data_addr_o = daddr_reg;
   assign ea_valid_o = val_reg;
   assign ea_o = ea_reg;
   assign branch_o = br_reg;
   assign imm_o = imm_reg;
   assign mode_o = mode_reg;
   assign len_o = lenq_reg;
   assign irq_level_o = mask_reg;
   assign halt_o = halt_reg;
   assign wait_o = wait_reg;

   // ==========================================================
   // assertions
   sequence s_end(logic [7:0] op);
      state_reg == ST_CALC && dec_reg.mode == M_INH && opc_reg == op;
   endsequence

   property p_short_page;
      @(posedge clk_i) disable iff (!arst_n_i)
      ea_valid_o && mode_o inside {M_DIR_S, M_IDX0, M_IND_S, M_BIT_D,
         M_BIT_I, M_BITREL_D, M_BITREL_I} |-> ea_o[15:8] == `ZERO_PAGE;
   endproperty
   a_short_page: assert property (p_short_page) // [RULE1] [RULE6] [RULE9]
      else $error("short form address left page zero");

   property p_long_len;
      @(posedge clk_i) disable iff (!arst_n_i)
      ea_valid_o && mode_o inside {M_DIR_L, M_IDX_L} |-> len_o >= `LEN_THREE;
   endproperty
   a_long_len: assert property (p_long_len) // [RULE2] [RULE7] [RULE11]
      else $error("long form too short");

   property p_rmw_short;
      @(posedge clk_i) disable iff (!arst_n_i)
      state_reg == ST_CALC && dec_reg.rmw |->
         !(dec_reg.mode inside {M_DIR_L, M_IDX_L, M_IND_L, M_IIDX_L});
   endproperty
   a_rmw_short: assert property (p_rmw_short) // [RULE3]
      else $error("read-modify-write row decoded long");

   property p_inh_len;
      @(posedge clk_i) disable iff (!arst_n_i)
      state_reg == ST_CALC && dec_reg.mode == M_INH |->
         len_reg == ((pre_reg == P_NONE) ? `LEN_ONE : `LEN_TWO);
   endproperty
   a_inh_len: assert property (p_inh_len) // [RULE4]
      else $error("inherent instruction fetched operand bytes");

   property p_imm;
      @(posedge clk_i) disable iff (!arst_n_i)
      ea_valid_o && mode_o == M_IMM |-> imm_o == opr_reg[7:0] &&
         len_o >= `LEN_TWO;
   endproperty
   a_imm: assert property (p_imm) // [RULE5]
      else $error("immediate value wrong");

   property p_idx_sum;
      @(posedge clk_i) disable iff (!arst_n_i)
      ea_valid_o && mode_o == M_IDX_S |->
         ea_o == {7'h00, {1'b0, opr_reg[7:0]} + {1'b0, idx_reg}};
   endproperty
   a_idx_sum: assert property (p_idx_sum) // [RULE8] [RULE10]
      else $error("short indexed sum wrong");

   property p_rel;
      @(posedge clk_i) disable iff (!arst_n_i)
      ea_valid_o && mode_o == M_REL_D |->
         ea_o == pc_reg + {{8{opr_reg[7]}}, opr_reg[7:0]};
   endproperty
   a_rel: assert property (p_rel) // [RULE14] [RULE15]
      else $error("relative target wrong");

   property p_mask;
      @(posedge clk_i) disable iff (!arst_n_i || pc_load_i)
      s_end(`OP_SET_MASK) |=> irq_level_o == `MASK_SET ##1
         irq_level_o == `MASK_SET;
   endproperty
   a_mask: assert property (p_mask) // [RULE19]
      else $error("mask level not 3 after set");

   property p_halt;
      @(posedge clk_i) disable iff (!arst_n_i)
      s_end(`OP_HALT) ##1 !wake_i |-> halt_o && !prog_rd_o;
   endproperty
   a_halt: assert property (p_halt) // [RULE20]
      else $error("halt not entered");

   property p_fetch_order;
      @(posedge clk_i) disable iff (!arst_n_i || pc_load_i)
      acc_p ##1 prog_rd_o |-> prog_addr_o == $past(prog_addr_o) + 16'h0001;
   endproperty
   a_fetch_order: assert property (p_fetch_order) // [RULE21]
      else $error("fetch address not ascending");

endmodule // cpu_addr_mode_decoder

// file: cpu_mem_model.sv
// Purpose: program or data memory that answers the decoder's byte reads
// Assumes: one read at a time; the request stays up until acknowledged
// Notes: delay_i sets the wait before each ack; idle data keeps toggling
`timescale 1ns/10ps
module cpu_mem_model #(
   parameter int AW = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // read request
   input wire logic rd_i,
   input wire logic [15:0] addr_i,
   input wire logic [3:0] delay_i,
   // answer
   output logic [7:0] data_o,
   output logic ack_o
);
   logic [7:0] mem [0:(1<<AW)-1];
   logic [3:0] cnt_reg;

   // ==========================================================
   // contents: an inherent filler byte everywhere
   initial begin
      for (int i = 0; i < (1<<AW); i++) mem[i] = 8'h9D;
   end

   // one-cycle ack after the wait; data is only good with the ack
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ack_o <= 1'b0;
         data_o <= 8'h00;
         cnt_reg <= 4'h0;
      end else begin
         ack_o <= 1'b0;
         data_o <= ~data_o; // no stale byte between answers
         if (rd_i && !ack_o) begin
            if (cnt_reg >= delay_i) begin
               ack_o <= 1'b1;
               data_o <= mem[addr_i[AW-1:0]];
               cnt_reg <= 4'h0;
            end else begin
               cnt_reg <= cnt_reg + 4'h1;
            end
         end
      end
   end
endmodule // cpu_mem_model

// file: tb_top.sv
// Purpose: self-checking bench of the operand address decoder
// Assumes: memory models on both byte ports
// Notes: each scenario loads code, jumps to it and checks the result
`timescale 1ns/10ps
module tb_top
   import cpu_addr_mode_pkg::*;
;
   logic clk_i, arst_n_i, pc_load_i, wake_i, prog_ack_i, data_ack_i;
   logic prog_rd_o, data_rd_o, ea_valid_o, halt_o, wait_o;
   logic [15:0] pc_value_i, prog_addr_o, data_addr_o, ea_o, branch_o;
   logic [7:0] x_i, y_i, prog_data_i, data_data_i, imm_o;
   logic [2:0] len_o;
   logic [1:0] irq_level_o;
   logic [3:0] dly;
   mode_type mode_o;
   int err_count, num_checks;

   // ==========================================================
   // design and memories
   cpu_addr_mode_decoder i_cpu_addr_mode_decoder (.clk_i, .arst_n_i,
      .pc_load_i, .pc_value_i, .wake_i, .x_i, .y_i, .prog_rd_o,
      .prog_addr_o, .prog_data_i, .prog_ack_i, .data_rd_o, .data_addr_o,
      .data_data_i, .data_ack_i, .ea_valid_o, .ea_o, .branch_o, .imm_o,
      .mode_o, .len_o, .irq_level_o, .halt_o, .wait_o);
   cpu_mem_model #(.AW(16)) i_prog_mem (.clk_i, .arst_n_i,
      .rd_i(prog_rd_o), .addr_i(prog_addr_o), .delay_i(dly),
      .data_o(prog_data_i), .ack_o(prog_ack_i));
   cpu_mem_model #(.AW(8)) i_data_mem (.clk_i, .arst_n_i,
      .rd_i(data_rd_o), .addr_i(data_addr_o), .delay_i(4'h1),
      .data_o(data_data_i), .ack_o(data_ack_i));

   // ==========================================================
   // shared tasks
   task automatic chk(input string nm, input logic [15:0] e, g);
      num_checks++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   // load three code bytes at pc, jump there, check the decoded result
   task automatic run(input logic [15:0] pc, input logic [23:0] code,
         input logic [7:0] xv, yv, input logic [15:0] ea,
         input logic [2:0] len, input mode_type md);
      int n;
      i_prog_mem.mem[pc] = code[23:16];
      i_prog_mem.mem[pc + 16'h0001] = code[15:8];
      i_prog_mem.mem[pc + 16'h0002] = code[7:0];
      @(posedge clk_i);
      x_i <= xv;
      y_i <= yv;
      pc_value_i <= pc;
      pc_load_i <= 1'b1;
      @(posedge clk_i);
      pc_load_i <= 1'b0;
      // skip a pulse of a filler instruction that ended in the same cycle as the load
      @(posedge clk_i);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (ea_valid_o !== 1'b1 && n < 100);
      chk("ea_valid", 16'h0001, {15'h0, ea_valid_o});
      chk("ea", ea, ea_o);
      chk("len", {13'h0, len}, {13'h0, len_o});
      chk("mode", 16'(md), 16'(mode_o));
   endtask

   // ==========================================================
   // scenarios
   task automatic t_inherent;
      run(16'h0010, 24'h9A9D9D, 8'h0, 8'h0, 16'h0, 3'h1, M_INH);
      chk("irq", 16'h0000, {14'h0, irq_level_o});
      run(16'h0010, 24'h9B9D9D, 8'h0, 8'h0, 16'h0, 3'h1, M_INH);
      chk("irq", 16'h0003, {14'h0, irq_level_o});
      run(16'h0020, 24'hA6559D, 8'h0, 8'h0, 16'h0, 3'h2, M_IMM);
      chk("imm", 16'h0055, {8'h0, imm_o});
      $display("test inherent done");
   endtask

   task automatic t_direct;
      run(16'h0030, 24'hB6109D, 8'h0, 8'h0, 16'h0010, 3'h2, M_DIR_S);
      dly <= 4'h3;
      run(16'hFF00, 24'hC61234, 8'h0, 8'h0, 16'h1234, 3'h3, M_DIR_L);
      dly <= 4'h0;
      run(16'h0040, 24'h3A209D, 8'h0, 8'h0, 16'h0020, 3'h2, M_DIR_S);
      run(16'h0040, 24'h7A9D9D, 8'h33, 8'h0, 16'h0033, 3'h1, M_IDX0);
      $display("test direct done");
   endtask

   task automatic t_indexed;
      run(16'h0050, 24'hF69D9D, 8'hFF, 8'h0, 16'h00FF, 3'h1, M_IDX0);
      run(16'h0050, 24'hE6FF9D, 8'hFF, 8'h0, 16'h01FE, 3'h2, M_IDX_S);
      run(16'h0050, 24'hD61234, 8'h10, 8'h0, 16'h1244, 3'h3, M_IDX_L);
      run(16'h0050, 24'h90E610, 8'h0, 8'h20, 16'h0030, 3'h3, M_IDX_S);
      $display("test indexed done");
   endtask

   task automatic t_indirect;
      i_data_mem.mem[8'h40] = 8'h12;
      i_data_mem.mem[8'h41] = 8'h34;
      i_data_mem.mem[8'h50] = 8'hFF;
      run(16'h0060, 24'h92B640, 8'h0, 8'h0, 16'h0012, 3'h3, M_IND_S);
      run(16'h0060, 24'h92C640, 8'h0, 8'h0, 16'h1234, 3'h3, M_IND_L);
      run(16'h0060, 24'h92E650, 8'hFF, 8'h0, 16'h01FE, 3'h3, M_IIDX_S);
      run(16'h0060, 24'h92D640, 8'h10, 8'h0, 16'h1244, 3'h3, M_IIDX_L);
      run(16'h0060, 24'h91E650, 8'h0, 8'h01, 16'h0100, 3'h3, M_IIDX_S);
      $display("test indirect done");
   endtask

   task automatic t_relative;
      i_data_mem.mem[8'h60] = 8'h03;
      run(16'h0100, 24'h20059D, 8'h0, 8'h0, 16'h0107, 3'h2, M_REL_D);
      chk("branch", 16'h0107, branch_o);
      run(16'h0100, 24'h20FE9D, 8'h0, 8'h0, 16'h0100, 3'h2, M_REL_D);
      run(16'h0300, 24'hAD109D, 8'h0, 8'h0, 16'h0312, 3'h2, M_REL_D);
      run(16'h0200, 24'h922060, 8'h0, 8'h0, 16'h0206, 3'h3, M_REL_I);
      chk("branch", 16'h0206, branch_o);
      run(16'h0500, 24'h051004, 8'h0, 8'h0, 16'h0010, 3'h3,
         M_BITREL_D);
      chk("branch", 16'h0507, branch_o);
      run(16'h0500, 24'h15209D, 8'h0, 8'h0, 16'h0020, 3'h2,
         M_BIT_D);
      chk("branch", 16'h0000, branch_o);
      run(16'h0500, 24'h921560, 8'h0, 8'h0, 16'h0003, 3'h3,
         M_BIT_I);
      $display("test relative done");
   endtask

   // halt then wait: fetch must stop until wake
   task automatic t_lowpow;
      for (int i = 0; i < 2; i++) begin
         run(16'h0400, {(i == 0) ? 8'h8E : 8'h8F, 16'h9D9D}, 8'h0, 8'h0,
            16'h0, 3'h1, M_INH);
         repeat (4) @(negedge clk_i);
         chk("halt", {15'h0, i == 0}, {15'h0, halt_o});
         chk("wait", {15'h0, i == 1}, {15'h0, wait_o});
         chk("prog_rd", 16'h0, {15'h0, prog_rd_o});
         @(posedge clk_i);
         wake_i <= 1'b1;
         @(posedge clk_i);
         wake_i <= 1'b0;
         repeat (2) @(negedge clk_i);
         chk("sleep", 16'h0, {14'h0, halt_o, wait_o});
      end
      $display("test low power done");
   endtask

   // ==========================================================
   // verdict, clock, watchdog and main sequence
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      end_sim();
   end

   initial begin
      arst_n_i = 1'b0;
      pc_load_i = 1'b0;
      pc_value_i = 16'h0000;
      wake_i = 1'b0;
      x_i = 8'h00;
      y_i = 8'h00;
      dly = 4'h0;
      repeat (12) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_inherent();
      t_direct();
      t_indexed();
      t_indirect();
      t_relative();
      t_lowpow();
      end_sim();
   end
endmodule // tb_top
